// [hw/dwph_pkg.sv]
package dwph_pkg;
	localparam int CLK_PERIOD_NS = 20;
	// address and data set-up the master must give ahead of a strobe
	localparam int T_SETUP_NS = 35;
	// least time AS* stays high between two cycles; plain default
	localparam int T_AS_HIGH_NS = 40;
	localparam int TMR_W = 4;

	function automatic logic [TMR_W-1:0] dwph_ceil_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		if (c < 1)
			c = 1;
		return c[TMR_W-1:0];
	endfunction

	localparam logic [TMR_W-1:0] SETUP_CYC = dwph_ceil_cycles(T_SETUP_NS);
	localparam logic [TMR_W-1:0] AS_HIGH_CYC = dwph_ceil_cycles(T_AS_HIGH_NS);

	localparam int ADDR_W = 31;
	localparam int AM_W = 6;
	localparam int DATA_W = 32;

	localparam logic [15:0] D16_PAD = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_IDLE = 31'h00000000;
	localparam logic [AM_W-1:0] AM_IDLE = 6'h00;
	localparam logic [DATA_W-1:0] DATA_IDLE = 32'h00000000;

	typedef enum logic [7:0] {
		DWPH_IDLE = 8'h01,
		DWPH_ARB = 8'h02,
		DWPH_ADDR = 8'h04,
		DWPH_SETUP = 8'h08,
		DWPH_DGATE = 8'h10,
		DWPH_DSET = 8'h20,
		DWPH_ACK = 8'h40,
		DWPH_RECOV = 8'h80
	} dwph_state_t;
endpackage

// [hw/dwph_delay.sv]
`timescale 1ns/1ps
module dwph_delay
	import dwph_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [TMR_W-1:0] load_val,
	output logic expired
);
	logic [TMR_W-1:0] cnt_reg;

	// rounds up by a cycle: safe for least times
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_reg <= '0;
			expired <= 1'b1;
		end else if (load) begin
			cnt_reg <= load_val;
			expired <= 1'b0;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
			expired <= (cnt_reg == {{(TMR_W-1){1'b0}}, 1'b1});
		end
	end
endmodule

// [hw/dwph_master.sv]
`timescale 1ns/1ps
module dwph_master
	import dwph_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [AM_W-1:0] cmd_am,
	input wire logic [DATA_W-1:0] cmd_data,
	input wire logic cmd_quad,
	input wire logic cmd_last,
	output logic cmd_ready,
	output logic cmd_done,
	output logic cmd_berr,
	input wire logic dtack_n_i,
	input wire logic berr_n_i,
	input wire logic as_n_i,
	output logic as_n_o,
	output logic as_n_oe,
	output logic ds0_n_o,
	output logic ds0_n_oe,
	output logic ds1_n_o,
	output logic ds1_n_oe,
	output logic write_n_o,
	output logic write_n_oe,
	output logic lword_n_o,
	output logic lword_n_oe,
	output logic iack_n_o,
	output logic iack_n_oe,
	output logic [ADDR_W-1:0] addr_o,
	output logic [AM_W-1:0] am_o,
	output logic addr_oe,
	output logic [DATA_W-1:0] data_o,
	output logic data_oe,
	output logic bus_req_o,
	input wire logic bus_grant_i,
	output logic bbsy_n_o,
	output logic bbsy_n_oe
);
	dwph_state_t st_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [AM_W-1:0] am_reg;
	logic [DATA_W-1:0] data_reg;
	logic quad_reg;
	logic last_reg;
	logic own_reg;
	logic fresh_reg;
	logic tmr_load;
	logic [TMR_W-1:0] tmr_val;
	logic tmr_done;
	logic bus_free;
	logic ack_seen;
	logic grant_ok;
	logic recov_exit;
	logic release_bus;

	assign bus_free = dtack_n_i && berr_n_i;
	assign ack_seen = !dtack_n_i || !berr_n_i;
	assign grant_ok = bus_grant_i && fresh_reg && as_n_i;
	assign recov_exit = (st_reg == DWPH_RECOV) && tmr_done && bus_free;
	assign release_bus = recov_exit && last_reg;
	assign tmr_load = (st_reg == DWPH_ADDR) || ((st_reg == DWPH_DGATE) && bus_free)
		|| ((st_reg == DWPH_ACK) && ack_seen);
	assign tmr_val = (st_reg == DWPH_ACK) ? AS_HIGH_CYC : SETUP_CYC;

	dwph_delay u_delay (
		.ref_clk(ref_clk),
		.rst(rst),
		.load(tmr_load),
		.load_val(tmr_val),
		.expired(tmr_done)
	);

	// grant must be seen low after our own release before it counts again
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fresh_reg <= 1'b1;
		end else if (!bus_grant_i) begin
			fresh_reg <= 1'b1;
		end else if (release_bus) begin
			fresh_reg <= 1'b0;
		end
	end

	// ownership: BBSY held low from grant until the last cycle's AS is released
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			own_reg <= 1'b0;
			bus_req_o <= 1'b0;
			bbsy_n_o <= 1'b1;
			bbsy_n_oe <= 1'b0;
		end else if (st_reg == DWPH_IDLE && cmd_valid && !own_reg) begin
			bus_req_o <= 1'b1;
		end else if (st_reg == DWPH_ARB && grant_ok) begin
			own_reg <= 1'b1;
			bus_req_o <= 1'b0;
			bbsy_n_o <= 1'b0;
			bbsy_n_oe <= 1'b1;
		end else if (release_bus) begin
			own_reg <= 1'b0;
			bbsy_n_o <= 1'b1;
			bbsy_n_oe <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_reg <= DWPH_IDLE;
			addr_reg <= ADDR_IDLE;
			am_reg <= AM_IDLE;
			data_reg <= DATA_IDLE;
			quad_reg <= 1'b0;
			last_reg <= 1'b0;
			cmd_ready <= 1'b1;
			cmd_done <= 1'b0;
			cmd_berr <= 1'b0;
			as_n_o <= 1'b1;
			as_n_oe <= 1'b0;
			ds0_n_o <= 1'b1;
			ds0_n_oe <= 1'b0;
			ds1_n_o <= 1'b1;
			ds1_n_oe <= 1'b0;
			write_n_o <= 1'b1;
			write_n_oe <= 1'b0;
			lword_n_o <= 1'b1;
			lword_n_oe <= 1'b0;
			iack_n_o <= 1'b1;
			iack_n_oe <= 1'b0;
			addr_o <= ADDR_IDLE;
			am_o <= AM_IDLE;
			addr_oe <= 1'b0;
			data_o <= DATA_IDLE;
			data_oe <= 1'b0;
		end else begin
			cmd_done <= 1'b0;
			unique case (st_reg)
				DWPH_IDLE: begin
					if (cmd_valid) begin
						addr_reg <= cmd_addr;
						am_reg <= cmd_am;
						data_reg <= cmd_quad ? cmd_data : {D16_PAD, cmd_data[15:0]};
						quad_reg <= cmd_quad;
						last_reg <= cmd_last;
						cmd_ready <= 1'b0;
						st_reg <= own_reg ? DWPH_ADDR : DWPH_ARB;
					end
				end
				DWPH_ARB: begin
					if (grant_ok)
						st_reg <= DWPH_ADDR;
				end
				DWPH_ADDR: begin
					addr_o <= addr_reg;
					am_o <= am_reg;
					addr_oe <= 1'b1;
					lword_n_o <= !quad_reg;
					lword_n_oe <= 1'b1;
					iack_n_o <= 1'b1;
					iack_n_oe <= 1'b1;
					write_n_o <= 1'b0;
					write_n_oe <= 1'b1;
					as_n_oe <= 1'b1;
					ds0_n_oe <= 1'b1;
					ds1_n_oe <= 1'b1;
					st_reg <= DWPH_SETUP;
				end
				DWPH_SETUP: begin
					if (tmr_done) begin
						as_n_o <= 1'b0;
						st_reg <= DWPH_DGATE;
					end
				end
				DWPH_DGATE: begin
					// previous responder may still be driving the data lines
					if (bus_free) begin
						data_o <= data_reg;
						data_oe <= 1'b1;
						st_reg <= DWPH_DSET;
					end
				end
				DWPH_DSET: begin
					if (tmr_done && bus_free) begin
						ds0_n_o <= 1'b0;
						ds1_n_o <= 1'b0;
						st_reg <= DWPH_ACK;
					end
				end
				DWPH_ACK: begin
					if (ack_seen) begin
						ds0_n_o <= 1'b1;
						ds1_n_o <= 1'b1;
						as_n_o <= 1'b1;
						if (last_reg) begin
							addr_oe <= 1'b0;
							data_oe <= 1'b0;
							lword_n_oe <= 1'b0;
							iack_n_oe <= 1'b0;
							write_n_oe <= 1'b0;
						end
						cmd_done <= 1'b1;
						cmd_berr <= !berr_n_i;
						st_reg <= DWPH_RECOV;
					end
				end
				DWPH_RECOV: begin
					// no pipelining: wait for the responder to let go first
					if (recov_exit) begin
						if (last_reg) begin
							as_n_oe <= 1'b0;
							ds0_n_oe <= 1'b0;
							ds1_n_oe <= 1'b0;
						end
						cmd_ready <= 1'b1;
						st_reg <= DWPH_IDLE;
					end
				end
			endcase
		end
	end

	property p_quad_order;
		@(posedge ref_clk) disable iff (rst)
		($fell(ds0_n_o) && quad_reg) |-> (!lword_n_o && lword_n_oe && iack_n_o && !as_n_o && !write_n_o && data_oe
			&& addr_oe);
	endproperty
	a_quad_order: assert property (p_quad_order) else $error("quad write strobed before its set-up");
	property p_data_gate;
		@(posedge ref_clk) disable iff (rst)
		$rose(data_oe) |-> ($past(dtack_n_i) && $past(berr_n_i));
	endproperty
	a_data_gate: assert property (p_data_gate) else $error("data driven while responder active");
	property p_strobe_gate;
		@(posedge ref_clk) disable iff (rst)
		$fell(ds1_n_o) |-> ($past(dtack_n_i) && $past(berr_n_i) && data_oe);
	endproperty
	a_strobe_gate: assert property (p_strobe_gate) else $error("strobe fell while responder active");
	property p_terminate;
		@(posedge ref_clk) disable iff (rst)
		(st_reg == DWPH_ACK && ack_seen) |=> (ds0_n_o && ds1_n_o && as_n_o && cmd_done
			&& (!last_reg || (!addr_oe && !data_oe && !lword_n_oe && !iack_n_oe)));
	endproperty
	a_terminate: assert property (p_terminate) else $error("cycle not terminated after acknowledge");
	property p_release_strobes;
		@(posedge ref_clk) disable iff (rst)
		release_bus |=> (!as_n_oe && !ds0_n_oe && !ds1_n_oe && !bbsy_n_oe ##1 cmd_ready);
	endproperty
	a_release_strobes: assert property (p_release_strobes) else $error("strobes kept after last cycle");
	property p_as_high_min;
		@(posedge ref_clk) disable iff (rst)
		($rose(as_n_o) && as_n_oe) |-> as_n_o [*3];
	endproperty
	a_as_high_min: assert property (p_as_high_min) else $error("AS high time too short");
	property p_no_pipeline;
		@(posedge ref_clk) disable iff (rst)
		(st_reg == DWPH_RECOV && !bus_free) |=> (as_n_o && st_reg == DWPH_RECOV);
	endproperty
	a_no_pipeline: assert property (p_no_pipeline) else $error("new cycle before responder release");
	property p_owned;
		@(posedge ref_clk) disable iff (rst)
		($fell(as_n_o) || $fell(ds0_n_o)) |-> (own_reg && !bbsy_n_o && bbsy_n_oe);
	endproperty
	a_owned: assert property (p_owned) else $error("transfer without bus ownership");
	property p_fresh_grant;
		@(posedge ref_clk) disable iff (rst)
		$rose(own_reg) |-> ($past(bus_grant_i) && $past(fresh_reg));
	endproperty
	a_fresh_grant: assert property (p_fresh_grant) else $error("ownership without fresh grant");
	property p_prev_as_free;
		@(posedge ref_clk) disable iff (rst)
		$rose(own_reg) |-> $past(as_n_i);
	endproperty
	a_prev_as_free: assert property (p_prev_as_free) else $error("took bus while AS still low");
	c_quad: cover property (@(posedge ref_clk) disable iff (rst) $fell(ds0_n_o) && quad_reg);
	c_d16: cover property (@(posedge ref_clk) disable iff (rst) $fell(ds0_n_o) && !quad_reg);
	c_berr: cover property (@(posedge ref_clk) disable iff (rst) cmd_done && cmd_berr);
	c_chain: cover property (@(posedge ref_clk) disable iff (rst) (st_reg == DWPH_IDLE) && cmd_valid && own_reg);
endmodule

// [test/dwph_slave_model.sv]
`timescale 1ns/1ps
module dwph_slave_model #(
	parameter logic [30:0] SLV_BASE = 31'h00012300,
	parameter logic [5:0] SLV_AM = 6'h0D
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic as_n,
	input wire logic ds0_n,
	input wire logic ds1_n,
	input wire logic write_n,
	input wire logic lword_n,
	input wire logic iack_n,
	input wire logic [30:0] addr,
	input wire logic [5:0] am,
	input wire logic [31:0] data,
	input wire logic force_berr,
	input wire logic [3:0] ack_dly,
	input wire logic [3:0] rel_dly,
	output logic dtack_n,
	output logic berr_n,
	output logic [31:0] stored_word,
	output logic lword_reg
);
	logic as_q_reg, ds_q_reg, sel_reg, run_reg;
	logic [3:0] cnt_reg;
	wire logic ds_low = ~ds0_n & ~ds1_n;
	always_ff @(posedge ref_clk) begin
		as_q_reg <= as_n;
		ds_q_reg <= ds_low;
		if (rst) begin
			sel_reg <= 1'b0;
			lword_reg <= 1'b1;
			run_reg <= 1'b0;
			cnt_reg <= 4'h0;
			dtack_n <= 1'b1;
			berr_n <= 1'b1;
			stored_word <= 32'h00000000;
		end else begin
			// decode held from each AS fall until the next AS fall, so later address changes cannot disturb it
			if (as_q_reg & ~as_n) begin
				sel_reg <= addr[30:8] == SLV_BASE[30:8] && am == SLV_AM && iack_n;
				lword_reg <= lword_n;
			end
			if (ds_low & ~ds_q_reg & ~write_n) begin
				run_reg <= 1'b1;
				cnt_reg <= ack_dly;
				if (sel_reg)
					stored_word <= lword_reg ? {16'h0000, data[15:0]} : data;
			end
			if (run_reg) begin
				if (cnt_reg != 4'h0)
					cnt_reg <= cnt_reg - 4'h1;
				else begin
					run_reg <= 1'b0;
					cnt_reg <= rel_dly;
					// unselected: stands in for the bus timer
					if (force_berr | ~sel_reg)
						berr_n <= 1'b0;
					else
						dtack_n <= 1'b0;
				end
			end
			// a slow release keeps the data lines busy into the next cycle
			if (as_n & ds0_n & ds1_n & ~run_reg) begin
				if (cnt_reg != 4'h0)
					cnt_reg <= cnt_reg - 4'h1;
				else begin
					dtack_n <= 1'b1;
					berr_n <= 1'b1;
				end
			end
		end
	end
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
	import dwph_pkg::*;
	localparam logic [30:0] BASE = 31'h00012300;
	localparam logic [5:0] AMOD = 6'h0D;
	logic ref_clk, rst, cmd_valid, cmd_quad, cmd_last, cmd_ready, cmd_done, cmd_berr;
	logic [30:0] cmd_addr, addr_o;
	logic [5:0] cmd_am, am_o;
	logic [31:0] cmd_data, data_o, stored_word;
	logic as_n_o, as_n_oe, ds0_n_o, ds0_n_oe, ds1_n_o, ds1_n_oe, write_n_o, write_n_oe;
	logic lword_n_o, lword_n_oe, iack_n_o, iack_n_oe, addr_oe, data_oe, bus_req_o, bbsy_n_o, bbsy_n_oe;
	logic dtack_n, berr_n, lword_reg, force_berr, grant_en, grant_force, other_as_n, doe_q, dsl_q;
	logic bus_grant_i = 1'b0;
	logic [3:0] ack_dly, rel_dly;
	int compares, miscompares;
	// released lines float to the terminator level
	wire logic as_w = (as_n_oe ? as_n_o : 1'b1) & other_as_n;
	wire logic ds0_w = ds0_n_oe ? ds0_n_o : 1'b1;
	wire logic ds1_w = ds1_n_oe ? ds1_n_o : 1'b1;
	wire logic ds_low = ~ds0_w & ~ds1_w;
	dwph_master dwph_master_inst (.ref_clk, .rst, .cmd_valid, .cmd_addr, .cmd_am, .cmd_data, .cmd_quad,
		.cmd_last, .cmd_ready, .cmd_done, .cmd_berr, .dtack_n_i(dtack_n), .berr_n_i(berr_n), .as_n_i(as_w),
		.as_n_o, .as_n_oe, .ds0_n_o, .ds0_n_oe, .ds1_n_o, .ds1_n_oe, .write_n_o, .write_n_oe, .lword_n_o,
		.lword_n_oe, .iack_n_o, .iack_n_oe, .addr_o, .am_o, .addr_oe, .data_o, .data_oe, .bus_req_o,
		.bus_grant_i, .bbsy_n_o, .bbsy_n_oe);
	dwph_slave_model #(.SLV_BASE(BASE), .SLV_AM(AMOD)) dwph_slave_model_inst (.ref_clk, .rst, .as_n(as_w),
		.ds0_n(ds0_w), .ds1_n(ds1_w), .write_n(write_n_oe ? write_n_o : 1'b1),
		.lword_n(lword_n_oe ? lword_n_o : 1'b1), .iack_n(iack_n_oe ? iack_n_o : 1'b1),
		.addr(addr_oe ? addr_o : '1), .am(addr_oe ? am_o : '1), .data(data_oe ? data_o : '1), .force_berr,
		.ack_dly, .rel_dly, .dtack_n, .berr_n, .stored_word, .lword_reg);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		bus_grant_i <= grant_force | (bus_req_o & grant_en);
		doe_q <= data_oe;
		dsl_q <= ds_low;
		if (!rst && ((data_oe && !doe_q) || (ds_low && !dsl_q)))
			chk("bus free", {dtack_n, berr_n}, 2'b11);
		if (!rst && !as_w && other_as_n)
			chk("owned", {bbsy_n_oe, bbsy_n_o}, 2'b10);
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic go(input logic [30:0] a, input logic [5:0] m, input logic [31:0] d, input logic q, input logic l);
		int n;
		n = 0;
		@(posedge ref_clk);
		while (cmd_ready !== 1'b1 && n < 300) begin
			@(posedge ref_clk);
			n++;
		end
		cmd_valid <= 1'b1;
		cmd_addr <= a;
		cmd_am <= m;
		cmd_data <= d;
		cmd_quad <= q;
		cmd_last <= l;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
	endtask
	task automatic fin(input logic eb);
		int n;
		n = 0;
		while (cmd_done !== 1'b1 && n < 300) begin
			@(posedge ref_clk);
			n++;
		end
		chk("done", cmd_done, 1'b1);
		chk("berr", cmd_berr, eb);
		chk("strobes", {as_w, ds0_w, ds1_w}, 3'b111);
	endtask
	task automatic t_quad;
		go(BASE | 31'h4, AMOD, 32'hA5C30F96, 1'b1, 1'b0);
		fin(1'b0);
		chk("word", stored_word, 32'hA5C30F96);
		chk("lword", lword_reg, 1'b0);
		go(BASE, AMOD, 32'h1234BEEF, 1'b0, 1'b1);
		fin(1'b0);
		chk("half", stored_word, 32'h0000BEEF);
		chk("lword", lword_reg, 1'b1);
		chk("release", {addr_oe, data_oe, lword_n_oe, iack_n_oe}, 4'h0);
		go(BASE, AMOD, 32'h0, 1'b1, 1'b1);
		chk("idle", {as_n_oe, ds0_n_oe, ds1_n_oe, bbsy_n_oe}, 4'h0);
		fin(1'b0);
		$display("test quad and half done");
	endtask
	task automatic t_berr;
		force_berr <= 1'b1;
		rel_dly <= 4'h6;
		go(BASE, AMOD, 32'h0F0F0F0F, 1'b1, 1'b0);
		fin(1'b1);
		force_berr <= 1'b0;
		go(BASE | 31'h8, 6'h3F, 32'h11111111, 1'b1, 1'b0);
		fin(1'b1);
		chk("kept", stored_word, 32'h0F0F0F0F);
		go(BASE | 31'h8, AMOD, 32'h80017FFE, 1'b1, 1'b1);
		fin(1'b0);
		chk("after slow", stored_word, 32'h80017FFE);
		rel_dly <= 4'h0;
		$display("test bus error done");
	endtask
	task automatic t_hold(input logic by_as);
		if (!by_as) begin
			// forced while this master is still arbitrating for the bus, so the grant stays high across its release and no longer counts as fresh
			go(BASE, AMOD, 32'h5555AAAA, 1'b1, 1'b1);
			grant_force <= 1'b1;
			fin(1'b0);
		end else
			other_as_n <= 1'b0;
		go(BASE, AMOD, 32'hC001D00D, 1'b1, 1'b1);
		repeat (12) @(posedge ref_clk);
		chk("no start", {as_n_oe, bbsy_n_oe, cmd_done}, 3'b000);
		grant_force <= 1'b0;
		grant_en <= 1'b0;
		other_as_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		grant_en <= 1'b1;
		fin(1'b0);
		chk("late word", stored_word, 32'hC001D00D);
		$display("test hold %0d done", by_as);
	endtask
	task automatic print_verdict;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge ref_clk);
		miscompares++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_addr = 31'h0;
		cmd_am = 6'h0;
		cmd_data = 32'h0;
		cmd_quad = 1'b0;
		cmd_last = 1'b0;
		force_berr = 1'b0;
		grant_en = 1'b1;
		grant_force = 1'b0;
		other_as_n = 1'b1;
		ack_dly = 4'h3;
		rel_dly = 4'h0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk("reset", {cmd_ready, bus_req_o, as_n_oe, data_oe, bbsy_n_oe}, 5'h10);
		t_quad();
		t_berr();
		t_hold(1'b0);
		t_hold(1'b1);
		print_verdict();
	end
endmodule
